// [common/led_ind_defs.vh]
`ifndef LED_IND_DEFS_VH
`define LED_IND_DEFS_VH
// Clock and timing
`define CLK_HZ 200000000
`define SELF_CHECK_US 1000
`define SELF_CHECK_CYC ((`SELF_CHECK_US * (`CLK_HZ / 1000000)))
`define PERIOD_1S_CYC (`CLK_HZ)
`define PERIOD_4S_CYC (4 * `CLK_HZ)
`define PERIOD_8TH_CYC (`CLK_HZ / 8)
`define HOLD_ZERO_S 3
`define HOLD_ZERO_CYC (`HOLD_ZERO_S * `CLK_HZ)
`define SHORT_FLASH_CYC (`CLK_HZ / 20)
// Pressure classes
`define PCLS_OVER1000 3'h0
`define PCLS_OVER800 3'h1
`define PCLS_NEAR760 3'h2
`define PCLS_BELOW700 3'h3
`define PCLS_BELOW1 3'h4
// LED colours
`define LED_OFF 2'h0
`define LED_GREEN 2'h1
`define LED_RED 2'h2
`define LED_YELLOW 2'h3
// Register offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_IRQ_STAT 4'h8
`define REG_IRQ_MASK 4'hc
// Bit positions
`define CTRL_CALIB 0
`define CTRL_COMM_ERR 1
`define CTRL_SENS_FAIL 2
`define IRQ_ZERO_TAKEN 0
`define IRQ_TOGGLE 1
`define IRQ_FAULT 2
`endif

// [hdl/period_gen.v]
`timescale 1ns/100ps
`include "led_ind_defs.vh"
// Free-running counter with a square phase output
module period_gen #(
  parameter PERIOD = 200
) (
  input wire clock,
  input wire rst,
  output reg [31:0] count_ff,
  output wire half
);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_ff <= 32'h0;
    end else if (count_ff == PERIOD - 1) begin
      count_ff <= 32'h0;
    end else begin
      count_ff <= count_ff + 32'h1;
    end
  end
  assign half = (count_ff < (PERIOD / 2));
endmodule // period_gen

// [hdl/hold_timer.v]
`timescale 1ns/100ps
// Counts cycles an input is held, saturating at LIMIT
module hold_timer #(
  parameter LIMIT = 600000000
) (
  input wire clock,
  input wire rst,
  input wire level,
  output wire reached
);
  reg [31:0] cnt_ff;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= 32'h0;
    end else if (!level) begin
      cnt_ff <= 32'h0;
    end else if (cnt_ff != LIMIT) begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end
  assign reached = (cnt_ff == LIMIT);
endmodule // hold_timer

// [hdl/led_indicator.v]
`timescale 1ns/100ps
`include "led_ind_defs.vh"
// Summary of operation
// R1: After power-up run a self-check before showing pressure patterns.
// R2: Above 1000 Torr vacuum flashes yellow 1 s; 800-1000 steady yellow.
// R3: Near 760 Torr both LEDs steady green.
// R4: Below 700 Torr vacuum flashes green 1 s, duty proportional to pressure.
// R5: Below 1 Torr vacuum gives short green flash each second.
// R6: Comm error: both flash red 4 s period, in alternation.
// R7: Sensor failure: both LEDs steady red.
// R8: Calibration: both flash green 1 s, in step.
// R9: Interface toggle: both flash green 1/8 s, alternating.
// R10: Forced zero: both flash green 1/8 s, in step.
// R11: Zero adjust: status steady green, vacuum flashes green 1/8 s.
// R12: Button held from power-up starts interface toggle, fast blink.
// R13: Faults first, then modes and button, pressure last.
// R14: Zero reset needs button held at least 3 seconds.
module led_indicator #(
  parameter SELF_CHECK_CYC = `SELF_CHECK_CYC,
  parameter P1S = `PERIOD_1S_CYC,
  parameter P4S = `PERIOD_4S_CYC,
  parameter P8TH = `PERIOD_8TH_CYC,
  parameter HOLD_CYC = `HOLD_ZERO_CYC,
  parameter SHORT_CYC = `SHORT_FLASH_CYC
) (
  input wire clock,
  input wire rst,
  input wire [2:0] pressure_class,
  input wire [7:0] pressure_frac,
  input wire self_check_ok,
  input wire button,
  input wire zero_adjust,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] status_led,
  output reg [1:0] vacuum_led,
  output reg zero_take,
  output reg iface_toggle,
  output wire irq
);
  // ----------------------------------------
  // Timebases
  // ----------------------------------------
  wire [31:0] c1;
  wire ph1;
  wire ph4;
  wire ph8;
  period_gen #(
    .PERIOD(P1S)
  ) u_p1 (
    .clock(clock),
    .rst(rst),
    .count_ff(c1),
    .half(ph1)
  );
  // Only the 1 s count is needed beyond the phase
  period_gen #(
    .PERIOD(P4S)
  ) u_p4 (
    .clock(clock),
    .rst(rst),
    .count_ff(),
    .half(ph4)
  );
  period_gen #(
    .PERIOD(P8TH)
  ) u_p8 (
    .clock(clock),
    .rst(rst),
    .count_ff(),
    .half(ph8)
  );

  // ----------------------------------------
  // Self-check and strap capture
  // ----------------------------------------
  localparam ST_CHECK = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_TOGGLE = 2'h2;
  reg [1:0] state_ff;
  reg [31:0] chk_ff;
  reg strap_ff;
  reg first_ff;
  reg [1:0] nxt_state;
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_CHECK: begin
        if (chk_ff >= SELF_CHECK_CYC && self_check_ok) begin // R1
          nxt_state = strap_ff ? ST_TOGGLE : ST_RUN;
        end
      end
      ST_TOGGLE: begin
        if (!button) begin // R12
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_CHECK;
    endcase
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= ST_CHECK;
      chk_ff <= 32'h0;
      strap_ff <= 1'b0;
      first_ff <= 1'b1;
      iface_toggle <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      first_ff <= 1'b0;
      // Strap caught on first clock after reset release
      if (first_ff) begin
        strap_ff <= button; // R12
      end else if (state_ff == ST_CHECK && !button) begin
        strap_ff <= 1'b0; // R12
      end
      if (state_ff == ST_CHECK && chk_ff < SELF_CHECK_CYC) begin
        chk_ff <= chk_ff + 32'h1;
      end
      iface_toggle <= (state_ff == ST_TOGGLE) && (nxt_state == ST_RUN);
    end
  end

  // ----------------------------------------
  // Push-button zero
  // ----------------------------------------
  wire held;
  reg held_d_ff;
  hold_timer #(
    .LIMIT(HOLD_CYC)
  ) u_hold (
    .clock(clock),
    .rst(rst),
    .level(button && state_ff == ST_RUN),
    .reached(held)
  );
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      held_d_ff <= 1'b0;
      zero_take <= 1'b0;
    end else begin
      held_d_ff <= held;
      zero_take <= held && !held_d_ff; // R14
    end
  end
  // Forced zero shown while button held past the threshold
  wire force_zero = held; // R10

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [2:0] ctrl_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_mask_ff;
  wire calib = ctrl_ff[`CTRL_CALIB];
  wire comm_err = ctrl_ff[`CTRL_COMM_ERR];
  wire sens_fail = ctrl_ff[`CTRL_SENS_FAIL];
  wire [2:0] events = {sens_fail | comm_err, iface_toggle, zero_take};
  wire wr_hit = avs_write && !avs_waitrequest;
  // One wait state on reads, so registered data stands at the accept edge
  reg rd_done_ff;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_done_ff <= 1'b0;
    end else begin
      rd_done_ff <= avs_read && !rd_done_ff;
    end
  end
  assign avs_waitrequest = avs_read && !rd_done_ff;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_ff <= 3'h0;
      irq_mask_ff <= 3'h0;
      irq_stat_ff <= 3'h0;
      avs_readdata <= 32'h0;
    end else begin
      if (wr_hit && avs_address == `REG_CTRL) begin
        ctrl_ff <= avs_writedata[2:0];
      end
      if (wr_hit && avs_address == `REG_IRQ_MASK) begin
        irq_mask_ff <= avs_writedata[2:0];
      end
      // Set wins over a same-cycle clear
      if (wr_hit && avs_address == `REG_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~avs_writedata[2:0]) | events;
      end else begin
        irq_stat_ff <= irq_stat_ff | events;
      end
      if (avs_read && !rd_done_ff) begin
        case (avs_address)
          `REG_CTRL: avs_readdata <= {29'h0, ctrl_ff};
          `REG_STATUS: avs_readdata <= {24'h0, status_led, vacuum_led, 2'h0, state_ff};
          `REG_IRQ_STAT: avs_readdata <= {29'h0, irq_stat_ff};
          `REG_IRQ_MASK: avs_readdata <= {29'h0, irq_mask_ff};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ----------------------------------------
  // Pattern selection
  // ----------------------------------------
  // Lit while c1 * 256 < P1S * frac; scaling up keeps short periods exact
  localparam [39:0] P1S_W = P1S;
  wire [39:0] duty_lim = P1S_W * {32'h0, pressure_frac};
  wire [39:0] duty_pos = {c1, 8'h00};
  wire duty_on = (duty_pos < duty_lim); // R4
  wire short_on = (c1 < SHORT_CYC); // R5
  localparam PAT_DARK = 4'h0;
  localparam PAT_FAIL = 4'h1;
  localparam PAT_COMM = 4'h2;
  localparam PAT_TOGGLE = 4'h3;
  localparam PAT_FORCE = 4'h4;
  localparam PAT_ADJUST = 4'h5;
  localparam PAT_CALIB = 4'h6;
  localparam PAT_PRESS = 4'h7;
  reg [3:0] pat;
  // Self-check blanking first, then faults, then modes and button, pressure last
  always @* begin
    pat = PAT_PRESS;
    if (state_ff == ST_CHECK) begin
      pat = PAT_DARK; // R1
    end else if (sens_fail) begin
      pat = PAT_FAIL; // R13
    end else if (comm_err) begin
      pat = PAT_COMM; // R13
    end else if (state_ff == ST_TOGGLE) begin
      pat = PAT_TOGGLE;
    end else if (force_zero) begin
      pat = PAT_FORCE;
    end else if (zero_adjust) begin
      pat = PAT_ADJUST;
    end else if (calib) begin
      pat = PAT_CALIB;
    end
  end
  // Vacuum colour from the pressure class
  reg [1:0] press_vac;
  always @* begin
    case (pressure_class)
      `PCLS_OVER1000: press_vac = ph1 ? `LED_YELLOW : `LED_OFF; // R2
      `PCLS_OVER800: press_vac = `LED_YELLOW; // R2
      `PCLS_NEAR760: press_vac = `LED_GREEN; // R3
      `PCLS_BELOW700: press_vac = duty_on ? `LED_GREEN : `LED_OFF; // R4
      `PCLS_BELOW1: press_vac = short_on ? `LED_GREEN : `LED_OFF; // R5
      default: press_vac = `LED_GREEN;
    endcase
  end
  reg [1:0] nxt_st;
  reg [1:0] nxt_vac;
  always @* begin
    nxt_st = `LED_OFF;
    nxt_vac = `LED_OFF;
    case (pat)
      PAT_DARK: begin
        nxt_st = `LED_OFF; // R1
        nxt_vac = `LED_OFF;
      end
      PAT_FAIL: begin
        nxt_st = `LED_RED; // R7
        nxt_vac = `LED_RED;
      end
      PAT_COMM: begin
        nxt_st = ph4 ? `LED_RED : `LED_OFF; // R6
        nxt_vac = ph4 ? `LED_OFF : `LED_RED;
      end
      PAT_TOGGLE: begin
        nxt_st = ph8 ? `LED_GREEN : `LED_OFF; // R9
        nxt_vac = ph8 ? `LED_OFF : `LED_GREEN;
      end
      PAT_FORCE: begin
        nxt_st = ph8 ? `LED_GREEN : `LED_OFF; // R10
        nxt_vac = ph8 ? `LED_GREEN : `LED_OFF;
      end
      PAT_ADJUST: begin
        nxt_st = `LED_GREEN; // R11
        nxt_vac = ph8 ? `LED_GREEN : `LED_OFF;
      end
      PAT_CALIB: begin
        nxt_st = ph1 ? `LED_GREEN : `LED_OFF; // R8
        nxt_vac = ph1 ? `LED_GREEN : `LED_OFF;
      end
      PAT_PRESS: begin
        nxt_st = `LED_GREEN; // R3
        nxt_vac = press_vac;
      end
      default: begin
        nxt_st = `LED_OFF;
        nxt_vac = `LED_OFF;
      end
    endcase
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      status_led <= `LED_OFF;
      vacuum_led <= `LED_OFF;
    end else begin
      status_led <= nxt_st;
      vacuum_led <= nxt_vac;
    end
  end
endmodule // led_indicator

// [verif/led_button_model.sv]
`timescale 1ns/100ps
// ----
// Push-button
// ----
// Contact follows the request one edge late, like a real press
module led_button_model (
  input wire clock,
  input wire press,
  output reg button
);
  initial button = 1'b0;
  always @(posedge clock) begin
    button <= press;
  end
endmodule // led_button_model

// [verif/led_indicator_checker.sv]
`timescale 1ns/100ps
module led_indicator_checker #(
  parameter SELF_CHECK_CYC = 10,
  parameter HOLD_CYC = 50
) (
  input wire clock,
  input wire rst,
  input wire button,
  input wire zero_adjust,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] status_led,
  input wire [1:0] vacuum_led,
  input wire zero_take,
  input wire iface_toggle,
  input wire irq
);
  // ----
  // Shadow state
  // ----
  reg [2:0] ctrl_ff;
  reg [31:0] up_ff;
  reg [31:0] held_ff;
  wire lit = status_led != 2'h0 || vacuum_led != 2'h0;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_ff <= 3'h0;
      up_ff <= 32'h0;
      held_ff <= 32'h0;
    end else begin
      if (avs_write && avs_address == 4'h0)
        ctrl_ff <= avs_writedata[2:0];
      if (up_ff < SELF_CHECK_CYC)
        up_ff <= up_ff + 32'h1;
      held_ff <= button ? held_ff + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----
  // Properties
  // ----
  // Two cycles of slack for input sampling and the registered output
  wait_low_a: assert property (avs_write |-> !avs_waitrequest) else $error("write waited");
  read_wait_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait too long");
  unmapped_zero_a: assert property (avs_read && avs_address[1:0] != 2'h0 |=>
    avs_readdata == 32'h0) else $error("unmapped read not zero");
  pulse_one_a: assert property (zero_take |=> !zero_take) else $error("zero pulse long");
  hold_long_a: assert property (zero_take |-> held_ff >= HOLD_CYC - 2)
    else $error("zero taken early");
  check_dark_a: assert property (up_ff < SELF_CHECK_CYC - 1 |-> !lit)
    else $error("lit during self-check");
  fail_red_a: assert property ((ctrl_ff[2] && lit) [*3] |->
    status_led == 2'h2 && vacuum_led == 2'h2) else $error("sensor fail not red");
  comm_alt_a: assert property ((ctrl_ff == 3'h2 && lit) [*3] |->
    {status_led, vacuum_led} == 4'h8 || {status_led, vacuum_led} == 4'h2)
    else $error("comm error not alternating");
  calib_sync_a: assert property ((ctrl_ff == 3'h1 && !button && !zero_adjust && lit) [*3] |->
    status_led == vacuum_led) else $error("calibration out of step");
  cover property (zero_take);
  cover property (iface_toggle);
  cover property (irq);
endmodule // led_indicator_checker
bind led_indicator led_indicator_checker #(.SELF_CHECK_CYC(SELF_CHECK_CYC), .HOLD_CYC(HOLD_CYC))
  u_led_indicator_checker (.*);

// [verif/led_indicator_tb_top.sv]
`timescale 1ns/100ps
module led_indicator_tb_top;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg press = 1'b1;
  reg [2:0] pressure_class = 3'h2;
  reg [7:0] pressure_frac = 8'h40;
  localparam SC_T = 10;
  localparam P1S_T = 80;
  localparam P4S_T = 320;
  localparam P8TH_T = 16;
  localparam HOLD_T = 50;
  localparam SHORT_T = 5;
  reg zero_adjust = 1'b0;
  reg self_check_ok = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire button;
  wire zero_take;
  wire iface_toggle;
  wire irq;
  wire [1:0] status_led;
  wire [1:0] vacuum_led;
  integer failures = 0;
  integer check_count = 0;
  integer sg, sr, vg, vr, vy, i;
  integer ev[0:4] = '{40, 80, 80, 20, 5};
  reg [31:0] rv;
  always #2.5 clock = ~clock;
  led_indicator #(.SELF_CHECK_CYC(SC_T), .P1S(P1S_T), .P4S(P4S_T), .P8TH(P8TH_T),
    .HOLD_CYC(HOLD_T), .SHORT_CYC(SHORT_T)) u_led_indicator (.clock(clock), .rst(rst),
    .pressure_class(pressure_class), .pressure_frac(pressure_frac),
    .self_check_ok(self_check_ok), .button(button),
    .zero_adjust(zero_adjust), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .status_led(status_led), .vacuum_led(vacuum_led),
    .zero_take(zero_take), .iface_toggle(iface_toggle), .irq(irq));
  led_button_model u_led_button_model (.clock(clock), .press(press), .button(button));
  // ----
  // Helpers
  // ----
  task chk(input string nm, input [31:0] e, input [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0s exp %0d got %0d", nm, e, g);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_write <= 1'b0;
  endtask
  // Data is taken at the edge that accepts the read
  task rd(input [3:0] a);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rv = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // Whole periods only, so the flash phase does not matter
  task meas(input integer n);
    repeat (4) @(posedge clock);
    {sg, sr, vg, vr, vy} = 0;
    repeat (n) begin
      @(posedge clock);
      sg += (status_led === 2'h1);
      sr += (status_led === 2'h2);
      vg += (vacuum_led === 2'h1);
      vr += (vacuum_led === 2'h2);
      vy += (vacuum_led === 2'h3);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_strap;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    meas(20);
    chk("check_dark", 0, sg + sr + vg + vr + vy);
    self_check_ok <= 1'b1;
    repeat (6) @(posedge clock);
    meas(32);
    chk("toggle_lit", 32, sg + vg);
    chk("toggle_half", 16, sg);
    press <= 1'b0;
    i = 0;
    while (iface_toggle !== 1'b1 && i < 40) begin
      @(posedge clock);
      i++;
    end
    chk("toggle_done", 1, iface_toggle);
    chk("irq_masked", 0, irq);
    wr(4'hc, 32'h2);
    @(posedge clock);
    chk("irq_on", 1, irq);
    wr(4'h8, 32'h2);
    repeat (2) @(posedge clock);
    chk("irq_clear", 0, irq);
  endtask
  task t_press;
    for (i = 0; i < 5; i++) begin
      pressure_class <= i[2:0];
      meas(80);
      chk("status", 80, sg);
      chk("vacuum", ev[i], i < 2 ? vy : vg);
    end
  endtask
  task t_fault;
    wr(4'h0, 32'h4);
    meas(80);
    chk("fail_red", 160, sr + vr);
    wr(4'h0, 32'h6);
    meas(80);
    chk("fail_first", 160, sr + vr);
    wr(4'h0, 32'h2);
    meas(320);
    chk("comm_sts", 160, sr);
    chk("comm_vac", 160, vr);
    wr(4'h0, 32'h1);
    meas(80);
    chk("cal", 80, sg + vg);
    wr(4'h0, 32'h0);
  endtask
  task t_zero;
    zero_adjust <= 1'b1;
    meas(16);
    chk("adj_sts", 16, sg);
    chk("adj_vac", 8, vg);
    press <= 1'b1;
    i = 0;
    while (zero_take !== 1'b1 && i < 80) begin
      @(posedge clock);
      i++;
    end
    chk("hold", 1, zero_take === 1'b1 && i >= HOLD_T);
    meas(16);
    chk("force", 16, sg + vg);
    chk("force_sync", sg, vg);
    press <= 1'b0;
    zero_adjust <= 1'b0;
    rd(4'h8);
    chk("zero_flag", 1, rv[0]);
    rd(4'h2);
    chk("unmapped", 0, rv);
    rd(4'h4);
    chk("run_state", 1, rv[1:0]);
  endtask
  task conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    t_strap;
    t_press;
    t_fault;
    t_zero;
    conclude;
  end
  initial begin
    #100000;
    failures++;
    conclude;
  end
endmodule // led_indicator_tb_top
